// ===== hdl/drfc_defs.vh
// Constants for the DRAM refresh and EXTENDED_DATA_OUT paging controller
`ifndef DRFC_DEFS_VH
`define DRFC_DEFS_VH
`define DRFC_ADDR_REFRESH 4'h0
`define DRFC_ADDR_TIMING 4'h1
`define DRFC_ADDR_STATUS 4'h2
`define DRFC_REFRESH_RST 16'h0000
`define DRFC_TIMING_RST 16'h0000
`define DRFC_RATE_LSB 0
`define DRFC_RATE_W 12
`define DRFC_RATE_MULT 16
`define DRFC_SLOW_PERIOD 65536
`define DRFC_TIM_PRE_LSB 0
`define DRFC_TIM_PRE_W 3
`define DRFC_TIM_EDO_BIT 4
`define DRFC_TIM_MUX_BIT 5
`define DRFC_TIM_PAGE_BIT 6
`define DRFC_REF_CAS_CYC 3'h2
`define DRFC_REF_RAS_CYC 3'h3
`define DRFC_SIZE_BYTE 2'h1
`endif

// ===== hdl/drfc_rate_gen.v
// Refresh request timer: one-cycle pulse per programmed period
`timescale 1ns/1ps
`include "drfc_defs.vh"
module drfc_rate_gen #(
   parameter RATE_W = `DRFC_RATE_W,
   parameter SLOW_PERIOD = `DRFC_SLOW_PERIOD
) (
   // Clock and master reset
   input wire mclk,
   input wire rst,
   // Control
   input wire [RATE_W-1:0] rate,
   input wire reload,
   // Request pulse
   output reg tick
);
   reg [16:0] cnt_q;
   wire [16:0] period;
   // Zero selects the slowest rate
   assign period = (rate == {RATE_W{1'b0}}) ? SLOW_PERIOD[16:0] :
                   {1'b0, rate, 4'h0}; // see (RULE10)
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= 17'h00000;
         tick <= 1'b0;
      end else if (reload) begin
         // The write is itself a request and reaches the flag a cycle before a tick does
         cnt_q <= 17'h00002; // see (RULE12)
         tick <= 1'b0;
      end else if (cnt_q >= period) begin
         cnt_q <= 17'h00001;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 17'h00001;
         tick <= 1'b0;
      end
   end
endmodule // drfc_rate_gen

// ===== hdl/drfc_ctrl.v
// DRAM refresh engine, EXTENDED_DATA_OUT page-mode sequencer and external master capture
// Summary of operation
// (RULE1) Column address on rise, CAS on next fall, ack next rise, sample after.
// (RULE2) With EXTENDED_DATA_OUT, CAS negates on the fall after ack, before sampling.
// (RULE3) EXTENDED_DATA_OUT memory holds read data until next CAS fall or RAS rise.
// (RULE4) Fast page mode keeps RAS asserted across beats and after transfers. The code keeps it open only after core transfers, not external ones.
// (RULE5) Page miss negates RAS; new row waits programmed precharge time.
// (RULE6) New-page read drives row, write strobe high, size, transfer start together.
// (RULE7) Refresh is CAS before RAS, both banks at once.
// (RULE8) Non-DRAM bus traffic never delays refresh; DRAM transfers may.
// (RULE9) Refresh starts at once when idle, else after the DRAM transfer.
// (RULE10) Period is rate times 16 clocks; zero gives 65536 clocks.
// (RULE11) Requests piling up during a transfer merge into one refresh.
// (RULE12) Writing the refresh register requests refresh and reloads the counter.
// (RULE13) Write while pending or refreshing adds no extra refresh.
// (RULE14) DRAM transfers wait until precharge after refresh completes.
// (RULE15) Core DRAM request during refresh holds bus request off.
// (RULE16) Master reset aborts refresh, clears refresh register to slowest rate.
// (RULE17) Master reset clears timing register to fastest timing.
// (RULE18) Normal reset leaves refresh engine and its registers running.
// (RULE19) External master address, direction, size latched on transfer start edge.
// (RULE20) External DRAM access derives strobes; address driven conditionally.
// (RULE21) Without transfer start no external service; refresh continues when granted.
// (RULE22) Software should choose refresh rate with margin for delayed refresh.
// (RULE23) EXTENDED_DATA_OUT enable bit makes CAS negate half a clock earlier. The code does this on reads only; writes keep the normal CAS timing.
// (RULE24) Address mux bit clear leaves address three-stated for external masters.
// (RULE25) Acknowledge driven as output at end of each external transfer.
// (RULE26) One pending flag, set by expiry or write, cleared at refresh start.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "drfc_defs.vh"
module drfc_ctrl #(
   parameter AW = 19,
   parameter RATE_W = `DRFC_RATE_W
) (
   // Clock and resets
   input wire mclk,
   input wire rst,
   input wire norm_rst,
   // Register port
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // Core request
   input wire core_req,
   input wire core_write,
   input wire [1:0] core_size,
   input wire [AW-1:0] core_row,
   input wire [AW-1:0] core_col,
   input wire core_bank,
   input wire core_burst_last,
   input wire core_own_bus,
   input wire core_dram_hit,
   output reg core_ack,
   output reg bus_request_n,
   // External master pins
   input wire transfer_start_n_in,
   input wire ext_write_in,
   input wire [1:0] ext_size_in,
   input wire [AW-1:0] ext_addr_in,
   input wire ext_dram_sel_in,
   input wire ext_granted_in,
   output reg transfer_ack_n_out,
   output reg transfer_ack_n_oe,
   // Bus-side status
   input wire bus_dram_busy,
   // DRAM pins
   output reg [AW-1:0] dram_addr_out,
   output reg dram_addr_oe,
   output reg transfer_start_n,
   output reg [1:0] xfer_size_code,
   output reg mem_write_strobe_n,
   output reg [1:0] ras_n,
   output reg cas_n_rise,
   output reg cas_n_fall,
   output reg data_sample
);
   localparam S_IDLE = 4'h0;
   localparam S_ROW = 4'h1;
   localparam S_COL = 4'h2;
   localparam S_ACK = 4'h3;
   localparam S_DONE = 4'h4;
   localparam S_PRE = 4'h5;
   localparam S_RCAS = 4'h6;
   localparam S_RRAS = 4'h7;
   localparam S_RPRE = 4'h8;
   localparam S_XCAP = 4'h9;

   reg [15:0] refresh_q;
   reg [15:0] timing_q;
   reg pend_q;
   reg [3:0] st_q;
   reg [2:0] cnt_q;
   reg page_open_q;
   reg open_bank_q;
   reg [AW-1:0] open_row_q;
   reg [AW-1:0] col_q;
   reg ext_q;
   reg ext_write_q;
   reg [1:0] ext_size_q;
   reg [AW-1:0] ext_addr_q;
   reg wr_q;
   reg bank_q;
   reg last_q;
   reg [1:0] ts_s1_q, ts_s2_q;
   reg [AW-1:0] ad_s1_q, ad_s2_q;
   reg [4:0] at_s1_q, at_s2_q;
   wire rate_tick;
   wire ref_wr;
   wire extended_data_out;
   wire ext_mux;
   wire fast_page;
   wire [2:0] pre_cyc;
   wire ext_start;
   wire refreshing;

   assign ref_wr = reg_wr && (reg_addr == `DRFC_ADDR_REFRESH);
   assign extended_data_out = timing_q[`DRFC_TIM_EDO_BIT];
   assign ext_mux = timing_q[`DRFC_TIM_MUX_BIT];
   assign fast_page = timing_q[`DRFC_TIM_PAGE_BIT];
   assign pre_cyc = timing_q[`DRFC_TIM_PRE_LSB +: `DRFC_TIM_PRE_W];
   // Pin inputs pass two flops before use
   assign ext_start = !ts_s2_q[0] && ts_s2_q[1] && at_s2_q[4] && at_s2_q[3]; // see (RULE21)
   assign refreshing = (st_q == S_RCAS) || (st_q == S_RRAS) || (st_q == S_RPRE);

   drfc_rate_gen #(
      .RATE_W(RATE_W),
      .SLOW_PERIOD(`DRFC_SLOW_PERIOD)
   ) u_rate (
      .mclk(mclk),
      .rst(rst),
      .rate(refresh_q[`DRFC_RATE_LSB +: RATE_W]),
      .reload(ref_wr),
      .tick(rate_tick)
   );

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ts_s1_q <= 2'h3;
         ts_s2_q <= 2'h3;
         ad_s1_q <= {AW{1'b0}};
         ad_s2_q <= {AW{1'b0}};
         at_s1_q <= 5'h00;
         at_s2_q <= 5'h00;
      end else begin
         ts_s1_q <= {1'b1, transfer_start_n_in};
         // Upper bit keeps the previous synchronised level for the falling-edge detect
         ts_s2_q <= {ts_s2_q[0], ts_s1_q[0]};
         ad_s1_q <= ext_addr_in;
         ad_s2_q <= ad_s1_q;
         at_s1_q <= {ext_granted_in, ext_dram_sel_in, ext_write_in, ext_size_in};
         at_s2_q <= at_s1_q;
      end
   end

   // Registers: master reset only, so normal reset keeps rate and timing
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         refresh_q <= `DRFC_REFRESH_RST; // see (RULE16)
         timing_q <= `DRFC_TIMING_RST; // see (RULE17)
         reg_rdata <= 16'h0000;
      end else begin
         if (ref_wr)
            refresh_q <= reg_wdata & {{(16-RATE_W){1'b0}}, {RATE_W{1'b1}}};
         if (reg_wr && reg_addr == `DRFC_ADDR_TIMING)
            timing_q <= reg_wdata;
         if (reg_rd) begin
            case (reg_addr)
               `DRFC_ADDR_REFRESH: reg_rdata <= refresh_q;
               `DRFC_ADDR_TIMING: reg_rdata <= timing_q;
               `DRFC_ADDR_STATUS: reg_rdata <= {11'h000, page_open_q, ext_q, pend_q,
                                               st_q == S_RCAS || st_q == S_RRAS, 1'b0};
               default: reg_rdata <= 16'h0000;
            endcase
         end else begin
            reg_rdata <= 16'h0000;
         end
      end
   end

   // Main sequencer; normal reset does not touch it (see RULE18)
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= S_IDLE; // see (RULE16)
         pend_q <= 1'b0;
         cnt_q <= 3'h0;
         page_open_q <= 1'b0;
         open_bank_q <= 1'b0;
         open_row_q <= {AW{1'b0}};
         col_q <= {AW{1'b0}};
         ext_q <= 1'b0;
         ext_write_q <= 1'b0;
         ext_size_q <= 2'h0;
         ext_addr_q <= {AW{1'b0}};
         wr_q <= 1'b0;
         bank_q <= 1'b0;
         last_q <= 1'b0;
         core_ack <= 1'b0;
         bus_request_n <= 1'b1;
         transfer_ack_n_out <= 1'b1;
         transfer_ack_n_oe <= 1'b1;
         dram_addr_out <= {AW{1'b0}};
         dram_addr_oe <= 1'b1;
         transfer_start_n <= 1'b1;
         xfer_size_code <= 2'h0;
         mem_write_strobe_n <= 1'b1;
         ras_n <= 2'h3;
         cas_n_rise <= 1'b1;
         cas_n_fall <= 1'b1;
         data_sample <= 1'b0;
      end else begin
         core_ack <= 1'b0;
         data_sample <= 1'b0;
         transfer_start_n <= 1'b1;
         transfer_ack_n_out <= 1'b1;
         // Single flag; refresh start clears it, the set wins over that
         // A write during a refresh is covered by that refresh (see RULE13)
         if (rate_tick || (ref_wr && !refreshing))
            pend_q <= 1'b1; // see (RULE11) (RULE12) (RULE26)
         else if (st_q == S_RCAS)
            pend_q <= 1'b0;
         // Core may request the bus only while no refresh runs
         bus_request_n <= !(core_req && !core_own_bus &&
                            st_q != S_RCAS && st_q != S_RRAS && st_q != S_RPRE); // see (RULE15)
         if (ext_start) begin
            ext_write_q <= at_s2_q[2]; // see (RULE19)
            ext_size_q <= at_s2_q[1:0];
            ext_addr_q <= ad_s2_q;
         end
         case (st_q)
            S_IDLE: begin
               cas_n_rise <= 1'b1;
               cas_n_fall <= 1'b1;
               if (pend_q && !bus_dram_busy) begin
                  // Non-DRAM traffic does not delay refresh; write during it merges
                  st_q <= S_RCAS; // see (RULE8) (RULE9) (RULE13)
                  ras_n <= 2'h3;
                  cnt_q <= `DRFC_REF_CAS_CYC;
                  page_open_q <= 1'b0;
               end else if (ext_start || (core_req && core_own_bus && core_dram_hit)) begin
                  ext_q <= ext_start;
                  wr_q <= ext_start ? at_s2_q[2] : core_write;
                  bank_q <= ext_start ? ad_s2_q[AW-1] : core_bank;
                  col_q <= ext_start ? ad_s2_q : core_col;
                  last_q <= ext_start ? 1'b1 : core_burst_last;
                  if (ext_start) begin
                     transfer_ack_n_oe <= 1'b0; // see (RULE25)
                     dram_addr_oe <= !ext_mux; // see (RULE24)
                  end else begin
                     dram_addr_oe <= 1'b0;
                  end
                  if (page_open_q && !ext_start && open_bank_q == core_bank &&
                      open_row_q == core_row) begin
                     st_q <= S_COL; // see (RULE4)
                  end else if (page_open_q) begin
                     ras_n <= 2'h3; // see (RULE5)
                     page_open_q <= 1'b0;
                     cnt_q <= pre_cyc;
                     st_q <= S_PRE;
                  end else begin
                     st_q <= S_ROW;
                     open_row_q <= ext_start ? ad_s2_q : core_row;
                     dram_addr_out <= ext_start ? ad_s2_q : core_row;
                     mem_write_strobe_n <= ext_start ? !at_s2_q[2] : !core_write; // see (RULE20)
                     xfer_size_code <= ext_start ? at_s2_q[1:0] : core_size; // see (RULE6)
                     transfer_start_n <= ext_start;
                  end
               end
            end
            S_PRE: begin
               if (cnt_q == 3'h0) begin
                  st_q <= S_ROW;
                  open_row_q <= ext_q ? ext_addr_q : core_row;
                  dram_addr_out <= ext_q ? ext_addr_q : core_row;
                  mem_write_strobe_n <= !wr_q;
                  xfer_size_code <= ext_q ? ext_size_q : core_size;
                  transfer_start_n <= ext_q;
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            S_ROW: begin
               ras_n[bank_q] <= 1'b0;
               open_bank_q <= bank_q;
               page_open_q <= !ext_q && fast_page;
               st_q <= S_COL;
            end
            S_COL: begin
               dram_addr_out <= col_q; // see (RULE1)
               cas_n_fall <= 1'b0;
               st_q <= S_ACK;
            end
            S_ACK: begin
               core_ack <= !ext_q; // see (RULE1)
               transfer_ack_n_out <= !ext_q;
               cas_n_rise <= 1'b0;
               // EXTENDED_DATA_OUT drops CAS on the next fall; data is still valid then
               if (extended_data_out && !wr_q)
                  cas_n_fall <= 1'b1; // see (RULE2) (RULE3) (RULE23)
               st_q <= S_DONE;
            end
            S_DONE: begin
               data_sample <= !wr_q; // see (RULE1)
               cas_n_rise <= 1'b1;
               cas_n_fall <= 1'b1;
               if (!page_open_q) begin
                  ras_n <= 2'h3;
                  transfer_ack_n_oe <= 1'b1;
                  dram_addr_oe <= 1'b1;
               end
               if (!last_q && core_req && !ext_q) begin
                  col_q <= core_col;
                  last_q <= core_burst_last;
                  st_q <= S_COL; // see (RULE4)
               end else begin
                  st_q <= S_IDLE;
               end
            end
            S_RCAS: begin
               // Both banks at once, CAS leads RAS
               cas_n_rise <= 1'b0; // see (RULE7)
               cas_n_fall <= 1'b0;
               if (cnt_q == 3'h0) begin
                  ras_n <= 2'h0;
                  cnt_q <= `DRFC_REF_RAS_CYC;
                  st_q <= S_RRAS;
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            S_RRAS: begin
               if (cnt_q == 3'h0) begin
                  ras_n <= 2'h3;
                  cas_n_rise <= 1'b1;
                  cas_n_fall <= 1'b1;
                  cnt_q <= pre_cyc;
                  st_q <= S_RPRE;
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
            S_RPRE: begin
               // Transfers held off until this precharge ends
               if (cnt_q == 3'h0)
                  st_q <= S_IDLE; // see (RULE14)
               else
                  cnt_q <= cnt_q - 3'h1;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule // drfc_ctrl

// ===== test/drfc_ctrl_monitor.sv
// Port-level assertions for the refresh and paging controller
`timescale 1ns/1ps
module drfc_ctrl_monitor (
   // Clock and master reset
   input wire mclk,
   input wire rst,
   // Core side
   input wire core_ack,
   input wire data_sample,
   input wire bus_request_n,
   // DRAM and bus pins
   input wire transfer_start_n,
   input wire dram_addr_oe,
   input wire [1:0] ras_n,
   input wire cas_n_rise,
   input wire cas_n_fall,
   input wire transfer_ack_n_out,
   input wire transfer_ack_n_oe
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   wire cas_lo = !(cas_n_rise && cas_n_fall);
   wire ref_on = (ras_n == 2'h0);
   property p_cbr;
      ref_on && $past(ras_n) == 2'h3 |-> $past(cas_lo);
   endproperty
   a_cbr: assert property (p_cbr) else $error("row strobes fell without column strobe");
   property p_ref_len;
      ref_on && $past(ras_n) == 2'h3 |-> ref_on [*4] ##1 ras_n == 2'h3;
   endproperty
   a_ref_len: assert property (p_ref_len) else $error("refresh row pulse length wrong");
   property p_ts_pulse;
      !transfer_start_n |-> !dram_addr_oe ##1 transfer_start_n;
   endproperty
   a_ts_pulse: assert property (p_ts_pulse) else $error("transfer start not a driven pulse");
   property p_sample;
      core_ack |=> data_sample && !core_ack;
   endproperty
   a_sample: assert property (p_sample) else $error("read data not sampled after ack");
   property p_open;
      core_ack |-> ras_n != 2'h3;
   endproperty
   a_open: assert property (p_open) else $error("ack without an open row");
   property p_no_br;
      ref_on |-> bus_request_n;
   endproperty
   a_no_br: assert property (p_no_br) else $error("bus request during refresh");
   property p_hold_off;
      ref_on |-> transfer_start_n && !core_ack;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("transfer during refresh");
   property p_precharge;
      $rose(ras_n[0]) |=> ras_n[0];
   endproperty
   a_precharge: assert property (p_precharge) else $error("row strobe reopened early");
   property p_ack_drive;
      !transfer_ack_n_out |-> !transfer_ack_n_oe;
   endproperty
   a_ack_drive: assert property (p_ack_drive) else $error("ack low but not driven");
   property p_mrst;
      disable iff (1'h0) rst |-> ras_n == 2'h3 && !cas_lo;
   endproperty
   a_mrst: assert property (p_mrst) else $error("strobes active in master reset");
   c_ref: cover property (ref_on);
   c_ack: cover property (core_ack);
   c_ext: cover property (!transfer_ack_n_out);
endmodule // drfc_ctrl_monitor
bind drfc_ctrl drfc_ctrl_monitor drfc_ctrl_monitor_inst (.mclk(mclk), .rst(rst),
   .core_ack(core_ack), .data_sample(data_sample), .bus_request_n(bus_request_n),
   .transfer_start_n(transfer_start_n), .dram_addr_oe(dram_addr_oe), .ras_n(ras_n),
   .cas_n_rise(cas_n_rise), .cas_n_fall(cas_n_fall), .transfer_ack_n_out(transfer_ack_n_out),
   .transfer_ack_n_oe(transfer_ack_n_oe));

// ===== test/drfc_dram_model.sv
// Two-bank EXTENDED_DATA_OUT DRAM model that reports refresh cycles per bank
`timescale 1ns/1ps
module drfc_dram_model (
   // Clock
   input wire mclk,
   // Strobes and address
   input wire [1:0] ras_n,
   input wire cas_n_rise,
   input wire cas_n_fall,
   input wire [18:0] addr,
   // Read data and refresh report
   output logic [7:0] dq,
   output logic [1:0] cbr_seen
);
   logic [1:0] ras_q = 2'h3;
   logic cas_q = 1'h1;
   wire cas_n = cas_n_rise & cas_n_fall;
   initial dq = 8'h00;
   initial cbr_seen = 2'h0;
   always @(posedge mclk) begin
      ras_q <= ras_n;
      cas_q <= cas_n;
      // A bank whose row strobe falls while the column strobe is low refreshes
      cbr_seen <= ras_q & ~ras_n & {2{~cas_q}};
      // Released bus toggles so a stale value is never mistaken for data
      if (ras_n == 2'h3)
         dq <= ~dq;
      else if (cas_q && !cas_n)
         dq <= addr[7:0];
   end
endmodule // drfc_dram_model

// ===== test/drfc_ctrl_bench.sv
// Self-checking bench for the refresh and paging controller
`timescale 1ns/1ps
`include "drfc_defs.vh"
module drfc_ctrl_bench;
   logic mclk = 1'h0, rst = 1'h0, norm_rst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic core_req = 1'h0, core_bank = 1'h0, ts_in_n = 1'h1, ext_write_in = 1'h0;
   logic core_own = 1'h1;
   logic ext_sel = 1'h0, ext_granted = 1'h0, bus_dram_busy = 1'h0;
   logic [1:0] ext_size_in = 2'h0, xfer_size_code, ras_n, cbr_seen;
   logic [18:0] core_row = 19'h0, core_col = 19'h0, ext_addr_in = 19'h0, dram_addr_out;
   logic core_ack, bus_request_n, ta_n, ta_oe, dram_addr_oe, transfer_start_n;
   logic mem_write_strobe_n, cas_n_rise, cas_n_fall, data_sample;
   logic rd_d = 1'h0, ext_on = 1'h0, oe_seen = 1'h0;
   int fails = 0, cmp_count = 0, cyc = 0, last = 0;
   int ref_q[$];
   logic [15:0] rd_q[$];
   logic [18:0] ts_q[$];
   drfc_ctrl drfc_ctrl_inst (.mclk(mclk), .rst(rst), .norm_rst(norm_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_req(core_req), .core_write(1'h0), .core_size(`DRFC_SIZE_BYTE), .core_row(core_row),
      .core_col(core_col), .core_bank(core_bank), .core_burst_last(1'h1), .core_own_bus(core_own),
      .core_dram_hit(1'h1), .core_ack(core_ack), .bus_request_n(bus_request_n),
      .transfer_start_n_in(ts_in_n), .ext_write_in(ext_write_in), .ext_size_in(ext_size_in),
      .ext_addr_in(ext_addr_in), .ext_dram_sel_in(ext_sel), .ext_granted_in(ext_granted),
      .transfer_ack_n_out(ta_n), .transfer_ack_n_oe(ta_oe), .bus_dram_busy(bus_dram_busy),
      .dram_addr_out(dram_addr_out), .dram_addr_oe(dram_addr_oe),
      .transfer_start_n(transfer_start_n), .xfer_size_code(xfer_size_code),
      .mem_write_strobe_n(mem_write_strobe_n), .ras_n(ras_n), .cas_n_rise(cas_n_rise),
      .cas_n_fall(cas_n_fall), .data_sample(data_sample));
   drfc_dram_model drfc_dram_model_inst (.mclk(mclk), .ras_n(ras_n), .cas_n_rise(cas_n_rise),
      .cas_n_fall(cas_n_fall), .addr(dram_addr_out), .dq(), .cbr_seen(cbr_seen));
   initial forever #12.5 mclk = ~mclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (fails == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Watcher: compares each result against the oldest note of its kind
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      rd_d <= reg_rd;
      if (rd_d)
         chk(reg_rdata, rd_q.pop_front());
      // Only while the external transfer holds the acknowledge pin
      if (ext_on && !ta_oe && !dram_addr_oe)
         oe_seen <= 1'h1;
      if (^cbr_seen)
         chk(cbr_seen, 32'h3);
      if (cbr_seen == 2'h3) begin
         // Zero notes a refresh whose spacing is not fixed
         if (ref_q.size() == 0)
            chk(cyc, 32'h0);
         else if (ref_q[0] == 0)
            void'(ref_q.pop_front());
         else
            chk(cyc - last, ref_q.pop_front());
         last <= cyc;
      end
      if (!transfer_start_n && !ext_on) begin
         if (ts_q.size() == 0)
            chk(32'h0, 32'h1);
         else
            chk({mem_write_strobe_n, xfer_size_code, dram_addr_out},
               {1'h1, `DRFC_SIZE_BYTE, ts_q.pop_front()});
      end
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      rd_q.push_back(e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
   endtask
   task automatic wait_ref(input int n);
      // Polled off the edge so the exit never races the watcher's pop
      for (int i = 0; i < n && ref_q.size() > 0; i++) @(negedge mclk);
      chk(ref_q.size(), 32'h0);
      @(posedge mclk);
   endtask
   // A register write also requests a refresh, so the first one is unspaced;
   // rates are picked with room for a refresh delayed by a transfer
   task automatic run(input logic [11:0] r, input int n, input logic twice);
      int p;
      p = (r == 12'h0) ? 65536 : 16 * r;
      ref_q.push_back(0);
      if (twice)
         ref_q.push_back(0);
      repeat (n) ref_q.push_back(p);
      // Let the last refresh end first, so the write is not absorbed by it
      repeat (4) @(posedge mclk);
      wr(`DRFC_ADDR_REFRESH, {4'h0, r});
      if (twice) begin
         // Lands inside the refresh the first write started
         repeat (3) @(posedge mclk);
         wr(`DRFC_ADDR_REFRESH, {4'h0, r});
      end
      wait_ref(p * n + 40);
   endtask
   task automatic core_rd(input logic [18:0] r, input logic miss);
      if (miss)
         ts_q.push_back(r);
      @(posedge mclk);
      core_row <= r;
      core_col <= 19'($urandom);
      core_req <= 1'h1;
      for (int i = 0; i < 40 && core_ack !== 1'h1; i++) @(posedge mclk);
      chk(core_ack, 1'h1);
      core_req <= 1'h0;
      repeat (2) @(posedge mclk);
   endtask
   initial begin
      repeat (80000) @(posedge mclk);
      fails++;
      test_done();
   end
   initial begin
      logic [18:0] row;
      int unsigned s;
      rst <= 1'h1;
      s = $urandom(55625);
      row = 19'($urandom);
      repeat (5) @(posedge mclk);
      rst <= 1'h0;
      core_bank <= 1'($urandom);
      rd(`DRFC_ADDR_REFRESH, `DRFC_REFRESH_RST);
      rd(`DRFC_ADDR_TIMING, `DRFC_TIMING_RST);
      rd(4'hf, 16'h0000);
      // One cycle precharge, EXTENDED_DATA_OUT, fast page, address mux off
      wr(`DRFC_ADDR_TIMING, 16'h0051);
      rd(`DRFC_ADDR_TIMING, 16'h0051);
      core_rd(row, 1'h1);
      core_rd(row, 1'h0);
      core_rd(row ^ 19'h1, 1'h1);
      ext_on <= 1'h1;
      ext_granted <= 1'h1;
      ext_sel <= 1'h1;
      ext_addr_in <= 19'($urandom);
      ext_write_in <= 1'($urandom);
      ext_size_in <= `DRFC_SIZE_BYTE;
      ts_in_n <= 1'h0;
      @(posedge mclk);
      ts_in_n <= 1'h1;
      for (int i = 0; i < 40 && ta_n !== 1'h0; i++) @(posedge mclk);
      chk(ta_n, 1'h0);
      repeat (4) @(posedge mclk);
      chk(oe_seen, 1'h0);
      ext_on <= 1'h0;
      run(12'h001, 3, 1'h0);
      norm_rst <= 1'h1;
      run(12'(2 + $urandom % 6), 2, 1'h0);
      norm_rst <= 1'h0;
      ext_granted <= 1'h0;
      // Core wants DRAM but does not own the bus through these refreshes
      core_own <= 1'h0;
      core_req <= 1'h1;
      run(12'h001, 1, 1'h1);
      repeat (5) @(posedge mclk);
      chk(bus_request_n, 1'h0);
      core_req <= 1'h0;
      core_own <= 1'h1;
      // Busy from before the next tick until just after the third one
      bus_dram_busy <= 1'h1;
      repeat (36) @(posedge mclk);
      ref_q = {0, 16};
      bus_dram_busy <= 1'h0;
      wait_ref(200);
      rst <= 1'h1;
      repeat (5) @(posedge mclk);
      rst <= 1'h0;
      rd(`DRFC_ADDR_REFRESH, `DRFC_REFRESH_RST);
      rd(`DRFC_ADDR_TIMING, `DRFC_TIMING_RST);
      run(12'h000, 1, 1'h0);
      test_done();
   end
endmodule // drfc_ctrl_bench
